// ---- ptm_defs.svh ----
// register offsets, field positions, reset values and widths of the order tracker
// assumes: included by bare name wherever the constants are needed
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

`define PTM_AXI_AW 8
`define PTM_AXI_DW 32

`define PTM_REG_CTRL 8'h00
`define PTM_REG_STATUS 8'h04
`define PTM_REG_RANK 8'h08
`define PTM_REG_OFFSET 8'h0C
`define PTM_REG_SEL 8'h10
`define PTM_REG_DATA 8'h14
`define PTM_REG_COUNT 8'h18
`define PTM_REG_LAST_FN 8'h1C

`define PTM_CTRL_METHOD_BIT 0
`define PTM_CTRL_LOG2_LSB 8
`define PTM_CTRL_LOG2_MSB 12
`define PTM_CTRL_LOG2_RST 5'h08
`define PTM_LOG2_MIN 5'h04
`define PTM_LOG2_MAX 5'h10

`define PTM_ST_WRAP_BIT 0
`define PTM_ST_RANGE_BIT 1

`define PTM_SEL_TBL_LSB 0
`define PTM_SEL_TBL_MSB 1
`define PTM_SEL_IDX_LSB 16
`define PTM_SEL_IDX_MSB 21
`define PTM_TBL_SEQ 2'h0
`define PTM_TBL_PIC 2'h1
`define PTM_TBL_RANK 2'h2

`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2

`define PTM_SEQ_SLOTS 16
`define PTM_PIC_SLOTS 64
`define PTM_RANK_SLOTS 16
`define PTM_FN_W 16
`define PTM_LSB_W 16
`define PTM_SET_W 32

`endif

// ---- ptm_pkg.sv ----
// shared types of the order tracker: bus states and coded unit kinds
// assumes: nothing beyond the language
package ptm_pkg;

	typedef enum logic [2:0] {
		PTM_BUS_IDLE = 3'b001,
		PTM_BUS_WRESP = 3'b010,
		PTM_BUS_RDATA = 3'b100
	} ptm_bus_st_t;

	typedef enum logic [2:0] {
		PTM_UNIT_SLICE = 3'h0,
		PTM_UNIT_PART_A = 3'h1,
		PTM_UNIT_PART_B = 3'h2,
		PTM_UNIT_PART_C = 3'h3,
		PTM_UNIT_SEQ_SET = 3'h4,
		PTM_UNIT_PIC_SET = 3'h5,
		PTM_UNIT_SUPP = 3'h6,
		PTM_UNIT_DELIM = 3'h7
	} ptm_unit_kind_t;

endpackage : ptm_pkg

// ---- ptm_tbl_if.sv ----
// write and read port of one slot table
// assumes: owner drives writes and read address, store answers one cycle later
interface ptm_tbl_if #(
	parameter int AW = 4,
	parameter int DW = 32
);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport owner (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ptm_tbl_if

// ---- ptm_tbl_mem.sv ----
// slot table memory with registered read data
// assumes: one clock, synchronous active-low reset, DEPTH equal to 2**AW
module ptm_tbl_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 32
) (
	input wire logic core_clk,
	input wire logic rst_b,
	ptm_tbl_if.store tbl
);

	typedef struct packed {
		logic [DW-1:0] rdata;
	} ptm_mem_state_t;

	ptm_mem_state_t s_q;
	ptm_mem_state_t s_d;
	logic [DW-1:0] mem_q [DEPTH];

	if (DEPTH != (1 << AW)) begin : g_bad_depth
		$error("ptm_tbl_mem: DEPTH must equal 2**AW");
	end

	always_comb begin
		s_d = s_q;
		s_d.rdata = mem_q[tbl.raddr];
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
		if (tbl.we) begin
			mem_q[tbl.waddr] <= tbl.wdata;
		end
	end

	assign tbl.rdata = s_q.rdata;

endmodule : ptm_tbl_mem

// ---- ptm_tracker.sv ----
// coded unit bookkeeping: parameter set slots, picture boundaries, output rank
// assumes: units arrive in decoding order on core_clk, registers over AXI4-Lite
`include "ptm_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module ptm_tracker #(
	parameter int FN_W = `PTM_FN_W,
	parameter int LSB_W = `PTM_LSB_W,
	parameter int SET_W = `PTM_SET_W
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic unit_valid,
	output logic unit_ready,
	input ptm_pkg::ptm_unit_kind_t unit_kind,
	input wire logic unit_instant_refresh,
	input wire logic [3:0] unit_sequence_set_selector,
	input wire logic [5:0] unit_picture_set_selector,
	input wire logic [SET_W-1:0] unit_set_payload,
	input wire logic [FN_W-1:0] unit_frame_num,
	input wire logic unit_storage_nonzero,
	input wire logic unit_redundant_flag,
	input wire logic [7:0] unit_redundant_cnt,
	input wire logic [LSB_W-1:0] unit_order_lsb,
	input wire logic [31:0] unit_order_delta,
	output logic pic_start,
	output logic [31:0] picture_output_rank,
	output logic order_error,
	input wire logic [`PTM_AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`PTM_AXI_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`PTM_AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`PTM_AXI_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	if (FN_W < 4 || FN_W > 32 || LSB_W < 16 || LSB_W > 31 || SET_W < 1 || SET_W > 32) begin : g_bad_param
		$error("ptm_tracker: width parameter out of range");
	end

	typedef struct packed {
		ptm_pkg::ptm_bus_st_t bus;
		logic awready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic method;
		logic [4:0] lsb_log2;
		logic [1:0] err;
		logic err_any;
		logic [1:0] sel_tbl;
		logic [5:0] sel_idx;
		logic unit_ready;
		logic have_prev;
		logic [FN_W-1:0] prev_fn;
		logic prev_sto;
		logic [LSB_W-1:0] prev_lsb;
		logic [31:0] prev_delta;
		logic [LSB_W-1:0] prior_lsb;
		logic [31:0] offset;
		logic [31:0] rank;
		logic pic_start;
		logic [31:0] pic_count;
		logic seq_pend;
		logic [3:0] seq_pend_id;
		logic [SET_W-1:0] seq_pend_data;
		logic pic_pend;
		logic [5:0] pic_pend_id;
		logic [SET_W-1:0] pic_pend_data;
		logic seq_we;
		logic [3:0] seq_wa;
		logic [SET_W-1:0] seq_wd;
		logic pic_we;
		logic [5:0] pic_wa;
		logic [SET_W-1:0] pic_wd;
		logic rk_we;
		logic [3:0] rk_wa;
		logic [31:0] rk_wd;
	} ptm_state_t;

	ptm_state_t s_q;
	ptm_state_t s_d;

	ptm_tbl_if #(.AW(4), .DW(SET_W)) seq_tbl ();
	ptm_tbl_if #(.AW(6), .DW(SET_W)) pic_tbl ();
	ptm_tbl_if #(.AW(4), .DW(32)) rank_tbl ();

	logic take;
	logic primary;
	logic new_pic;
	logic [31:0] lsb_range;
	logic [31:0] lsb_half;
	logic [31:0] lsb_ext;
	logic [31:0] prior_ext;
	logic [31:0] off_add;
	logic [31:0] off_sub;
	logic [31:0] off_next;
	logic [31:0] rank_next;
	logic off_ovf;
	logic rank_ovf;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] zext_set(input logic [SET_W-1:0] v);
		logic [31:0] r;
		r = '0;
		r[SET_W-1:0] = v;
		return r;
	endfunction : zext_set

	function automatic logic add_ovf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] sum);
		return (a[31] == b[31]) && (sum[31] != a[31]);
	endfunction : add_ovf

	////////////////////////////////////////////////////////////////////////////
	// order arithmetic

	always_comb begin
		take = unit_valid && s_q.unit_ready;
		primary = !unit_redundant_flag || (unit_redundant_cnt == 8'h00);
		lsb_range = 32'h1 << s_q.lsb_log2;
		lsb_half = lsb_range >> 1;
		lsb_ext = 32'(unit_order_lsb);
		prior_ext = 32'(s_q.prior_lsb);
		new_pic = !s_q.have_prev || (unit_frame_num != s_q.prev_fn)
			|| (!s_q.prev_sto && unit_storage_nonzero)
			|| (!s_q.method && unit_order_lsb != s_q.prev_lsb)
			|| (s_q.method && unit_order_delta != s_q.prev_delta);
		off_add = s_q.offset + lsb_range;
		off_sub = s_q.offset - lsb_range;
		off_ovf = 1'b0;
		if (lsb_ext < prior_ext && (prior_ext - lsb_ext) >= lsb_half) begin
			off_next = off_add;
			off_ovf = add_ovf(s_q.offset, lsb_range, off_add);
		end else if (lsb_ext > prior_ext && (lsb_ext - prior_ext) >= lsb_half) begin
			off_next = off_sub;
			off_ovf = add_ovf(s_q.offset, ~lsb_range + 32'h1, off_sub);
		end else begin
			off_next = s_q.offset;
		end
		rank_next = off_next + lsb_ext;
		rank_ovf = add_ovf(off_next, lsb_ext, rank_next);
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		s_d.pic_start = 1'b0;
		s_d.seq_we = 1'b0;
		s_d.pic_we = 1'b0;
		s_d.rk_we = 1'b0;

		// register bus
		case (s_q.bus)
			ptm_pkg::PTM_BUS_IDLE: begin
				if (s_q.awready) begin
					s_d.awready = 1'b0;
					s_d.bvalid = 1'b1;
					s_d.bresp = `PTM_RESP_OKAY;
					s_d.bus = ptm_pkg::PTM_BUS_WRESP;
					case ({s_axi_awaddr[`PTM_AXI_AW-1:2], 2'b00})
						`PTM_REG_CTRL: begin
							if (s_axi_wstrb[0]) begin
								s_d.method = s_axi_wdata[`PTM_CTRL_METHOD_BIT];
							end
							if (s_axi_wstrb[1]
								&& s_axi_wdata[`PTM_CTRL_LOG2_MSB:`PTM_CTRL_LOG2_LSB] >= `PTM_LOG2_MIN
								&& s_axi_wdata[`PTM_CTRL_LOG2_MSB:`PTM_CTRL_LOG2_LSB] <= `PTM_LOG2_MAX) begin
								s_d.lsb_log2 = s_axi_wdata[`PTM_CTRL_LOG2_MSB:`PTM_CTRL_LOG2_LSB];
							end
						end
						`PTM_REG_STATUS: begin
							if (s_axi_wstrb[0]) begin
								s_d.err = s_q.err & ~s_axi_wdata[1:0];
							end
						end
						`PTM_REG_SEL: begin
							if (s_axi_wstrb[0]) begin
								s_d.sel_tbl = s_axi_wdata[`PTM_SEL_TBL_MSB:`PTM_SEL_TBL_LSB];
							end
							if (s_axi_wstrb[2]) begin
								s_d.sel_idx = s_axi_wdata[`PTM_SEL_IDX_MSB:`PTM_SEL_IDX_LSB];
							end
						end
						`PTM_REG_RANK, `PTM_REG_OFFSET, `PTM_REG_DATA, `PTM_REG_COUNT, `PTM_REG_LAST_FN: begin
							s_d.bresp = `PTM_RESP_OKAY;
						end
						default: begin
							s_d.bresp = `PTM_RESP_SLVERR;
						end
					endcase
				end else if (s_q.arready) begin
					s_d.arready = 1'b0;
					s_d.rvalid = 1'b1;
					s_d.rresp = `PTM_RESP_OKAY;
					s_d.bus = ptm_pkg::PTM_BUS_RDATA;
					case ({s_axi_araddr[`PTM_AXI_AW-1:2], 2'b00})
						`PTM_REG_CTRL: s_d.rdata = {19'h0, s_q.lsb_log2, 7'h0, s_q.method};
						`PTM_REG_STATUS: s_d.rdata = {30'h0, s_q.err};
						`PTM_REG_RANK: s_d.rdata = s_q.rank;
						`PTM_REG_OFFSET: s_d.rdata = s_q.offset;
						`PTM_REG_SEL: s_d.rdata = {10'h0, s_q.sel_idx, 14'h0, s_q.sel_tbl};
						`PTM_REG_DATA: begin
							case (s_q.sel_tbl)
								`PTM_TBL_SEQ: s_d.rdata = zext_set(seq_tbl.rdata);
								`PTM_TBL_PIC: s_d.rdata = zext_set(pic_tbl.rdata);
								`PTM_TBL_RANK: s_d.rdata = rank_tbl.rdata;
								default: s_d.rdata = 32'h0;
							endcase
						end
						`PTM_REG_COUNT: s_d.rdata = s_q.pic_count;
						`PTM_REG_LAST_FN: s_d.rdata = 32'(s_q.prev_fn);
						default: begin
							s_d.rdata = 32'h0;
							s_d.rresp = `PTM_RESP_SLVERR;
						end
					endcase
				end else if (s_axi_awvalid && s_axi_wvalid) begin
					s_d.awready = 1'b1;
				end else if (s_axi_arvalid) begin
					s_d.arready = 1'b1;
				end
			end
			ptm_pkg::PTM_BUS_WRESP: begin
				if (s_axi_bready) begin
					s_d.bvalid = 1'b0;
					s_d.bus = ptm_pkg::PTM_BUS_IDLE;
				end
			end
			ptm_pkg::PTM_BUS_RDATA: begin
				if (s_axi_rready) begin
					s_d.rvalid = 1'b0;
					s_d.bus = ptm_pkg::PTM_BUS_IDLE;
				end
			end
			default: begin
				s_d.bus = ptm_pkg::PTM_BUS_IDLE;
			end
		endcase

		// coded units
		if (take) begin
			case (unit_kind)
				ptm_pkg::PTM_UNIT_SEQ_SET: begin
					if (s_q.seq_pend && s_q.seq_pend_id != unit_sequence_set_selector) begin
						s_d.seq_we = 1'b1;
						s_d.seq_wa = s_q.seq_pend_id;
						s_d.seq_wd = s_q.seq_pend_data;
					end
					s_d.seq_pend = 1'b1;
					s_d.seq_pend_id = unit_sequence_set_selector;
					s_d.seq_pend_data = unit_set_payload;
				end
				ptm_pkg::PTM_UNIT_PIC_SET: begin
					if (s_q.pic_pend && s_q.pic_pend_id != unit_picture_set_selector) begin
						s_d.pic_we = 1'b1;
						s_d.pic_wa = s_q.pic_pend_id;
						s_d.pic_wd = s_q.pic_pend_data;
					end
					s_d.pic_pend = 1'b1;
					s_d.pic_pend_id = unit_picture_set_selector;
					s_d.pic_pend_data = unit_set_payload;
				end
				ptm_pkg::PTM_UNIT_SLICE, ptm_pkg::PTM_UNIT_PART_A: begin
					if (unit_instant_refresh && s_q.seq_pend) begin
						s_d.seq_we = 1'b1;
						s_d.seq_wa = s_q.seq_pend_id;
						s_d.seq_wd = s_q.seq_pend_data;
						s_d.seq_pend = 1'b0;
					end
					if (s_q.pic_pend) begin
						s_d.pic_we = 1'b1;
						s_d.pic_wa = s_q.pic_pend_id;
						s_d.pic_wd = s_q.pic_pend_data;
						s_d.pic_pend = 1'b0;
					end
					if (primary) begin
						s_d.have_prev = 1'b1;
						s_d.prev_fn = unit_frame_num;
						s_d.prev_sto = unit_storage_nonzero;
						s_d.prev_lsb = unit_order_lsb;
						s_d.prev_delta = unit_order_delta;
						if (32'(unit_order_lsb) >= lsb_range) begin
							s_d.err[`PTM_ST_RANGE_BIT] = 1'b1;
						end
						if (new_pic) begin
							s_d.pic_start = 1'b1;
							s_d.pic_count = s_q.pic_count + 32'h1;
							if (unit_instant_refresh) begin
								s_d.offset = 32'h0;
								s_d.rank = 32'h0;
								s_d.prior_lsb = '0;
							end else if (!s_q.method) begin
								s_d.offset = off_next;
								s_d.rank = rank_next;
								s_d.prior_lsb = unit_order_lsb;
								if (off_ovf || rank_ovf) begin
									s_d.err[`PTM_ST_WRAP_BIT] = 1'b1;
								end
							end
							if (unit_storage_nonzero) begin
								s_d.rk_we = 1'b1;
								s_d.rk_wa = unit_frame_num[3:0];
								s_d.rk_wd = (unit_instant_refresh || s_q.method) ? s_d.rank : rank_next;
							end
						end
					end
				end
				default: begin
					s_d.unit_ready = 1'b1;
				end
			endcase
		end
		s_d.err_any = |s_d.err;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.bus <= ptm_pkg::PTM_BUS_IDLE;
			s_q.lsb_log2 <= `PTM_CTRL_LOG2_RST;
			s_q.unit_ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slot tables

	assign seq_tbl.we = s_q.seq_we;
	assign seq_tbl.waddr = s_q.seq_wa;
	assign seq_tbl.wdata = s_q.seq_wd;
	assign seq_tbl.raddr = s_q.sel_idx[3:0];
	assign pic_tbl.we = s_q.pic_we;
	assign pic_tbl.waddr = s_q.pic_wa;
	assign pic_tbl.wdata = s_q.pic_wd;
	assign pic_tbl.raddr = s_q.sel_idx;
	assign rank_tbl.we = s_q.rk_we;
	assign rank_tbl.waddr = s_q.rk_wa;
	assign rank_tbl.wdata = s_q.rk_wd;
	assign rank_tbl.raddr = s_q.sel_idx[3:0];

	ptm_tbl_mem #(.DEPTH(`PTM_SEQ_SLOTS), .AW(4), .DW(SET_W)) u_seq_mem (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tbl(seq_tbl.store)
	);

	ptm_tbl_mem #(.DEPTH(`PTM_PIC_SLOTS), .AW(6), .DW(SET_W)) u_pic_mem (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tbl(pic_tbl.store)
	);

	ptm_tbl_mem #(.DEPTH(`PTM_RANK_SLOTS), .AW(4), .DW(32)) u_rank_mem (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tbl(rank_tbl.store)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign unit_ready = s_q.unit_ready;
	assign pic_start = s_q.pic_start;
	assign picture_output_rank = s_q.rank;
	assign order_error = s_q.err_any;
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.awready;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rvalid = s_q.rvalid;

endmodule : ptm_tracker

// ---- ptm_tracker_checker.sv ----
// checker: picture boundary and output rank properties of the order tracker
// assumes: bound to ptm_tracker, control fields followed from the write channels
`include "ptm_defs.svh"
module ptm_tracker_checker #(
	parameter int FN_W = 16,
	parameter int LSB_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic unit_valid,
	input wire logic unit_ready,
	input ptm_pkg::ptm_unit_kind_t unit_kind,
	input wire logic unit_instant_refresh,
	input wire logic [FN_W-1:0] unit_frame_num,
	input wire logic unit_storage_nonzero,
	input wire logic unit_redundant_flag,
	input wire logic [7:0] unit_redundant_cnt,
	input wire logic [LSB_W-1:0] unit_order_lsb,
	input wire logic [31:0] unit_order_delta,
	input wire logic pic_start,
	input wire logic [31:0] picture_output_rank,
	input wire logic order_error,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb
);
	logic seen_q, st_q, meth_q, prim, same, new_pic, m0;
	logic [FN_W-1:0] fn_q;
	logic [LSB_W-1:0] lsb_q, pri_q;
	logic [31:0] dl_q;
	logic [4:0] lg_q;
	int off_q, rng, dd, er;
	////////////////////////////////////////
	always_comb begin
		rng = 1 << lg_q;
		dd = int'(unit_order_lsb) - int'(pri_q);
		er = off_q + int'(unit_order_lsb) + (dd <= -(rng / 2) ? rng : (dd >= rng / 2 ? -rng : 0));
		prim = unit_valid && unit_ready;
		prim = prim && (unit_kind == ptm_pkg::PTM_UNIT_SLICE || unit_kind == ptm_pkg::PTM_UNIT_PART_A);
		prim = prim && (!unit_redundant_flag || unit_redundant_cnt == 8'h00);
		same = seen_q && unit_frame_num == fn_q;
		new_pic = !same || (!st_q && unit_storage_nonzero);
		new_pic = prim && (new_pic || (meth_q ? unit_order_delta != dl_q : unit_order_lsb != lsb_q));
		m0 = new_pic && !meth_q && !unit_instant_refresh && int'(unit_order_lsb) < rng;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			seen_q <= 1'b0;
			meth_q <= 1'b0;
			lg_q <= 5'h08;
			off_q <= 0;
			pri_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `PTM_REG_CTRL) begin
				if (s_axi_wstrb[0]) meth_q <= s_axi_wdata[0];
				if (s_axi_wstrb[1] && s_axi_wdata[12:8] >= 5'h04 && s_axi_wdata[12:8] <= 5'h10) lg_q <= s_axi_wdata[12:8];
			end
			if (prim) begin
				seen_q <= 1'b1;
				fn_q <= unit_frame_num;
				st_q <= unit_storage_nonzero;
				lsb_q <= unit_order_lsb;
				dl_q <= unit_order_delta;
			end
			if (new_pic && unit_instant_refresh) begin
				off_q <= 0;
				pri_q <= '0;
			end else if (new_pic && !meth_q) begin
				off_q <= er - int'(unit_order_lsb);
				pri_q <= unit_order_lsb;
			end
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_ready; unit_ready; endproperty
	a_ready: assert property (p_ready) else $error("unit not accepted");
	property p_cause; pic_start |-> $past(new_pic); endproperty
	a_cause: assert property (p_cause) else $error("picture start without cause");
	property p_fn; prim && seen_q && unit_frame_num != fn_q |=> pic_start; endproperty
	a_fn: assert property (p_fn) else $error("frame change missed");
	property p_store; prim && same && !st_q && unit_storage_nonzero |=> pic_start; endproperty
	a_store: assert property (p_store) else $error("storage rise missed");
	property p_field; prim && same && (meth_q ? unit_order_delta != dl_q : unit_order_lsb != lsb_q) |=> pic_start; endproperty
	a_field: assert property (p_field) else $error("order field change missed");
	property p_refresh; new_pic && unit_instant_refresh |=> pic_start && picture_output_rank == 32'h0; endproperty
	a_refresh: assert property (p_refresh) else $error("refresh rank not zero");
	property p_up; m0 && dd <= -(rng / 2) |=> picture_output_rank == $past(er); endproperty
	a_up: assert property (p_up) else $error("rank after drop wrong");
	property p_dn; m0 && dd >= rng / 2 |=> picture_output_rank == $past(er); endproperty
	a_dn: assert property (p_dn) else $error("rank after rise wrong");
	property p_keep; m0 && dd > -(rng / 2) && dd < rng / 2 |=> picture_output_rank == $past(er); endproperty
	a_keep: assert property (p_keep) else $error("rank without wrap wrong");
	property p_err; new_pic && !meth_q && int'(unit_order_lsb) >= rng |-> ##[1:2] order_error; endproperty
	a_err: assert property (p_err) else $error("oversize order field not flagged");
endmodule : ptm_tracker_checker

bind ptm_tracker ptm_tracker_checker #(.FN_W(FN_W), .LSB_W(LSB_W)) chk_u (
	.core_clk, .rst_b, .unit_valid, .unit_ready, .unit_kind, .unit_instant_refresh, .unit_frame_num,
	.unit_storage_nonzero, .unit_redundant_flag, .unit_redundant_cnt, .unit_order_lsb, .unit_order_delta,
	.pic_start, .picture_output_rank, .order_error, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb
);

// ---- ptm_src_model.sv ----
// partner: system layer handing coded units to the tracker
// assumes: unit_ready sampled on the rising edge of core_clk
module ptm_src_model (
	input wire logic core_clk,
	input wire logic unit_ready,
	output logic unit_valid,
	output ptm_pkg::ptm_unit_kind_t unit_kind,
	output logic unit_instant_refresh,
	output logic [3:0] unit_sequence_set_selector,
	output logic [5:0] unit_picture_set_selector,
	output logic [31:0] unit_set_payload,
	output logic [15:0] unit_frame_num,
	output logic unit_storage_nonzero,
	output logic unit_redundant_flag,
	output logic [7:0] unit_redundant_cnt,
	output logic [15:0] unit_order_lsb,
	output logic [31:0] unit_order_delta
);
	timeunit 1ns;
	timeprecision 100ps;
	logic v_q = 1'b0;
	logic [77:0] h_q = '0;
	assign unit_valid = v_q;
	assign unit_kind = ptm_pkg::ptm_unit_kind_t'(h_q[77:75]);
	assign {unit_instant_refresh, unit_frame_num, unit_storage_nonzero} = h_q[74:57];
	assign {unit_redundant_flag, unit_redundant_cnt, unit_order_lsb, unit_order_delta} = h_q[56:0];
	assign unit_sequence_set_selector = unit_order_lsb[3:0];
	assign unit_picture_set_selector = unit_order_lsb[5:0];
	assign unit_set_payload = unit_order_delta;
	////////////////////////////////////////
	// one unit per call in caller order, held until taken
	// callers keep partitions, extras and delimiters behind the first unit of their picture
	task automatic send(input logic [77:0] h);
		v_q <= 1'b1;
		h_q <= h;
		do @(posedge core_clk); while (!unit_ready);
	endtask : send
	// released lines show the inverse of the last unit
	task automatic rest();
		v_q <= 1'b0;
		h_q <= ~h_q;
		@(posedge core_clk);
	endtask : rest
endmodule : ptm_src_model

// ---- tb_top.sv ----
// testbench: unit stream and register bus tests of the order tracker
// assumes: design, partner model and checker compiled before
`include "ptm_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic unit_valid, unit_ready, unit_instant_refresh, unit_storage_nonzero, unit_redundant_flag;
	logic pic_start, order_error;
	ptm_pkg::ptm_unit_kind_t unit_kind;
	logic [3:0] unit_sequence_set_selector;
	logic [5:0] unit_picture_set_selector;
	logic [7:0] unit_redundant_cnt;
	logic [15:0] unit_frame_num, unit_order_lsb;
	logic [31:0] unit_set_payload, unit_order_delta, picture_output_rank, s_axi_rdata;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int compares = 0;
	int miscompares = 0;
	int starts = 0;
	always @(posedge core_clk) begin
		if (pic_start === 1'b1) starts <= starts + 1;
	end
	always #2.5 core_clk = ~core_clk;
	ptm_src_model src_u (.core_clk, .unit_ready, .unit_valid, .unit_kind, .unit_instant_refresh,
		.unit_sequence_set_selector, .unit_picture_set_selector, .unit_set_payload, .unit_frame_num,
		.unit_storage_nonzero, .unit_redundant_flag, .unit_redundant_cnt, .unit_order_lsb, .unit_order_delta);
	ptm_tracker dut_u (.core_clk, .rst_b, .unit_valid, .unit_ready, .unit_kind, .unit_instant_refresh,
		.unit_sequence_set_selector, .unit_picture_set_selector, .unit_set_payload, .unit_frame_num,
		.unit_storage_nonzero, .unit_redundant_flag, .unit_redundant_cnt, .unit_order_lsb, .unit_order_delta,
		.pic_start, .picture_output_rank, .order_error, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0, input logic [3:0] st = 4'hF);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
			end
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0, input logic [31:0] m = '1);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				chk("rdata", s_axi_rdata & m, e);
				chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
			end
		end while (s_axi_arvalid || s_axi_rready);
	endtask : rd
	task automatic sl(input logic [15:0] fn, input logic st, input logic [8:0] rc, input logic [15:0] lsb, input logic [31:0] dl);
		src_u.send({ptm_pkg::PTM_UNIT_SLICE, 1'b0, fn, st, rc, lsb, dl});
	endtask : sl
	task automatic end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rd(`PTM_REG_RANK, 32'h0);
		rd(`PTM_REG_OFFSET, 32'h0);
		rd(8'h20, 32'h0, `PTM_RESP_SLVERR);
		wr(8'h24, 32'h0, `PTM_RESP_SLVERR);
		wr(`PTM_REG_RANK, 32'h1234_5678);
		rd(`PTM_REG_RANK, 32'h0);
		wr(`PTM_REG_CTRL, 32'h0000_0400);
		wr(`PTM_REG_CTRL, 32'h0000_0300);
		rd(`PTM_REG_CTRL, 32'h0000_0400);
		src_u.send({ptm_pkg::PTM_UNIT_PIC_SET, 1'b0, 16'h0, 1'b0, 9'h0, 16'h0021, 32'h5A5A_0021});
		src_u.send({ptm_pkg::PTM_UNIT_SEQ_SET, 1'b0, 16'h0, 1'b0, 9'h0, 16'h0005, 32'hA5A5_0005});
		src_u.send({ptm_pkg::PTM_UNIT_SLICE, 1'b1, 16'h0, 1'b1, 9'h0, 16'h0, 32'h0});
		src_u.send({ptm_pkg::PTM_UNIT_DELIM, 1'b0, 16'h7, 1'b1, 9'h0, 16'h7, 32'h7});
		src_u.send({ptm_pkg::PTM_UNIT_SUPP, 1'b0, 16'h7, 1'b1, 9'h0, 16'h7, 32'h7});
		sl(16'h1, 1'b1, 9'h0, 16'h4, 32'h0);
		sl(16'h1, 1'b1, 9'h0, 16'h4, 32'h0);
		sl(16'h2, 1'b0, 9'h0, 16'h6, 32'h0);
		sl(16'h2, 1'b1, 9'h0, 16'h6, 32'h0);
		sl(16'h2, 1'b1, 9'h0, 16'hE, 32'h0);
		src_u.rest();
		rd(`PTM_REG_COUNT, 32'h5);
		rd(`PTM_REG_OFFSET, 32'hFFFF_FFF0);
		rd(`PTM_REG_RANK, 32'hFFFF_FFFE);
		wr(`PTM_REG_SEL, 32'h0005_0000);
		rd(`PTM_REG_DATA, 32'hA5A5_0005);
		wr(`PTM_REG_SEL, 32'h0021_0001);
		rd(`PTM_REG_DATA, 32'h5A5A_0021);
		wr(`PTM_REG_SEL, 32'h0001_0002);
		rd(`PTM_REG_DATA, 32'h4);
		sl(16'h3, 1'b1, 9'h0, 16'h2, 32'h0);
		sl(16'h9, 1'b1, 9'h101, 16'h2, 32'h0);
		sl(16'h4, 1'b1, 9'h100, 16'h5, 32'h0);
		src_u.rest();
		rd(`PTM_REG_COUNT, 32'h7);
		rd(`PTM_REG_OFFSET, 32'h0);
		rd(`PTM_REG_RANK, 32'h5);
		rd(`PTM_REG_LAST_FN, 32'h4);
		chk("rank port", picture_output_rank, 32'h5);
		sl(16'h5, 1'b1, 9'h0, 16'h10, 32'h0);
		src_u.rest();
		rd(`PTM_REG_STATUS, 32'h2, 2'h0, 32'h2);
		chk("error flag", {31'h0, order_error}, 32'h1);
		wr(`PTM_REG_CTRL, 32'h0000_0C01, 2'h0, 4'h1);
		rd(`PTM_REG_CTRL, 32'h0000_0401);
		sl(16'h5, 1'b1, 9'h0, 16'h10, 32'h0);
		sl(16'h5, 1'b1, 9'h0, 16'h10, 32'h3);
		src_u.send({ptm_pkg::PTM_UNIT_PART_A, 1'b0, 16'h6, 1'b1, 9'h0, 16'h10, 32'h3});
		src_u.send({ptm_pkg::PTM_UNIT_PART_B, 1'b0, 16'h7, 1'b1, 9'h0, 16'h7, 32'h7});
		src_u.send({ptm_pkg::PTM_UNIT_PART_C, 1'b0, 16'h7, 1'b1, 9'h0, 16'h7, 32'h7});
		src_u.rest();
		rd(`PTM_REG_COUNT, 32'hA);
		chk("picture starts", starts, 32'hA);
		wr(`PTM_REG_STATUS, 32'h3);
		rd(`PTM_REG_STATUS, 32'h0);
		chk("error flag", {31'h0, order_error}, 32'h0);
		end_sim();
	end
endmodule : tb_top
